// file: dv/core_model.sv
// Behavioural core: machine-cycle ticks, final-cycle flag and returns
`timescale 1ns/100ps
module core_model #(
    parameter int MC = 6
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             leave_req,
    input  wire logic             mid_instr,
    output irq_ctl_pkg::core_in_s core_in
);
    import irq_ctl_pkg::*;
    // ==================
    // Machine cycle of MC clocks, one tick at its end
    int cnt_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 0;
            core_in <= '0;
        end else begin
            cnt_r              <= (cnt_r == MC - 1) ? 0 : cnt_r + 1;
            core_in.mc_tick    <= (cnt_r == MC - 2);
            core_in.last_cycle <= !mid_instr;
            core_in.return_from_irq       <= leave_req;
        end
    end
endmodule : core_model

// file: dv/tb.sv
// Self-checking bench for the prioritised vectored interrupt controller
`timescale 1ns/100ps
`include "irq_ctl_defs.svh"
module tb;
    import irq_ctl_pkg::*;
    localparam int MC = 6;
    typedef struct packed {
        logic [10:0] fl;
        logic [9:0]  pv;
        logic [7:0]  ea;
        logic [7:0]  eb;
        logic [7:0]  ec;
        logic [15:0] vec;
        logic [3:0]  idx;
        logic [10:0] fx;
    } row_s;
    logic        clk_sys;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        leave_req;
    logic        mid_instr;
    core_in_s    core_in;
    periph_s     per_v;
    pins_s       pin_v;
    core_out_s   core_out;
    logic [31:0] rd;
    int          fails;
    int          total_checks;
    // ==================
    // One source per row; 7FF in the last column skips the flag check
    row_s rows [14] = '{
        '{11'h100, 10'h000, 8'h81, 8'h00, 8'h01, 16'h0003, 4'h0, 11'h000},
        '{11'h000, 10'h020, 8'h80, 8'h01, 8'h00, 16'h0043, 4'h1, 11'h001},
        '{11'h000, 10'h200, 8'h82, 8'h00, 8'h00, 16'h000B, 4'h2, 11'h000},
        '{11'h002, 10'h000, 8'h80, 8'h02, 8'h00, 16'h004B, 4'h3, 11'h000},
        '{11'h200, 10'h000, 8'h84, 8'h00, 8'h02, 16'h0013, 4'h4, 11'h000},
        '{11'h000, 10'h002, 8'h80, 8'h04, 8'h00, 16'h0053, 4'h5, 11'h004},
        '{11'h000, 10'h100, 8'h88, 8'h00, 8'h00, 16'h001B, 4'h6, 11'h000},
        '{11'h008, 10'h000, 8'h80, 8'h08, 8'h00, 16'h005B, 4'h7, 11'h000},
        '{11'h000, 10'h080, 8'h90, 8'h00, 8'h00, 16'h0023, 4'h8, 11'h000},
        '{11'h010, 10'h000, 8'h80, 8'h10, 8'h00, 16'h0063, 4'h9, 11'h000},
        '{11'h000, 10'h040, 8'hA0, 8'h00, 8'h00, 16'h002B, 4'hA, 11'h040},
        '{11'h020, 10'h000, 8'h80, 8'h20, 8'h00, 16'h006B, 4'hB, 11'h000},
        '{11'h080, 10'h000, 8'hA0, 8'h00, 8'h00, 16'h002B, 4'hA, 11'h080},
        '{11'h000, 10'h001, 8'h80, 8'h00, 8'h00, 16'h007B, 4'hC, 11'h7FF}
    };
    prioritized_vector_interrupt_ctl #(
        .VEC_W(16)
    ) u_prioritized_vector_interrupt_ctl (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .core_in   (core_in),
        .periph    (per_v),
        .pins      (pin_v),
        .core_out  (core_out)
    );
    core_model #(
        .MC(MC)
    ) u_core_model (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .leave_req (leave_req),
        .mid_instr (mid_instr),
        .core_in   (core_in)
    );
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    // ==================
    // Bus master, compare and call tasks
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        cmp($sformatf("reg %0h", a), e & m, rd & m);
    endtask : rd_chk
    task automatic leave_isr();
        @(posedge clk_sys);
        leave_req <= 1'b1;
        @(posedge clk_sys);
        leave_req <= 1'b0;
    endtask : leave_isr
    task automatic expect_call(input logic [15:0] vec, input logic [3:0] idx);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (core_out.call !== 1'b1 && n < 12 * MC);
        cmp("vector", 32'(vec), 32'(core_out.vector));
        cmp("ack", 32'h1 << idx, 32'(core_out.ack));
        n = 0;
        while (core_out.call === 1'b1 && n < 4 * MC) begin
            @(negedge clk_sys);
            n++;
        end
        cmp("call length", 32'(2 * MC), 32'(n));
    endtask : expect_call
    task automatic expect_none(input int cyc);
        int n;
        n = 0;
        repeat (cyc) begin
            @(negedge clk_sys);
            if (core_out.call !== 1'b0) n++;
        end
        cmp("stray call", 32'h0, 32'(n));
    endtask : expect_none
    task automatic run_row(input row_s r);
        logic [3:0] isv_e;
        // Wake runs at the top level, every other row at level zero
        isv_e = (r.idx == 4'hC) ? 4'h8 : 4'h1;
        wr(`REG_EN_A, 32'(r.ea));
        wr(`REG_EN_B, 32'(r.eb));
        wr(`REG_EXT_CTL, 32'(r.ec));
        wr(`REG_FLAGS, 32'(r.fl));
        per_v <= r.pv;
        expect_call(r.vec, r.idx);
        @(posedge clk_sys);
        per_v <= '0;
        rd_chk(`REG_STATUS, {4'h0, r.vec, 8'h00, isv_e}, 32'h0FFFF00F);
        if (r.fx !== 11'h7FF) rd_chk(`REG_FLAGS, 32'(r.fx), 32'h7FF);
        wr(`REG_FLAGS, 32'h0);
        wr(`REG_EN_A, 32'h0);
        leave_isr();
        rd_chk(`REG_STATUS, 32'h0, 32'hF);
    endtask : run_row
    task automatic reload_pulse();
        pin_v.t2_reload_pin <= 1'b1;
        repeat (2 * MC) @(posedge clk_sys);
        pin_v.t2_reload_pin <= 1'b0;
        repeat (2 * MC) @(posedge clk_sys);
    endtask : reload_pulse
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // ==================
    // Watchdog: the whole run needs well under two thousand clocks
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        finish_test();
    end
    // ==================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        leave_req = 1'b0;
        mid_instr = 1'b0;
        per_v = '0;
        pin_v = 7'h03;
        fails = 0;
        total_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        wr(8'h1C, 32'hFF);
        for (int a = 0; a < 32; a += 4) begin
            rd_chk(8'(a), 32'h0, 32'hFFFFFFFF);
        end
        cmp("hresp", 32'h0, 32'(hresp));
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Levels: soft group at level 2, the rest at level 0
        wr(`REG_PRIO_HI, 32'h02);
        wr(`REG_EN_B, 32'h03);
        wr(`REG_EXT_CTL, 32'h01);
        wr(`REG_EN_A, 32'h81);
        wr(`REG_FLAGS, 32'h003);
        expect_call(16'h004B, 4'h3);
        wr(`REG_FLAGS, 32'h101);
        expect_none(4 * MC);
        leave_isr();
        expect_call(16'h0003, 4'h0);
        wr(`REG_FLAGS, 32'h003);
        expect_call(16'h004B, 4'h3);
        rd_chk(`REG_STATUS, 32'h5, 32'hF);
        wr(`REG_FLAGS, 32'h0);
        wr(`REG_EN_A, 32'h0);
        wr(`REG_PRIO_HI, 32'h0);
        leave_isr();
        rd_chk(`REG_STATUS, 32'h1, 32'hF);
        leave_isr();
        // Blocked mid-instruction, then withdrawn: must be forgotten
        wr(`REG_EN_A, 32'h80);
        mid_instr <= 1'b1;
        wr(`REG_FLAGS, 32'h002);
        expect_none(3 * MC);
        wr(`REG_FLAGS, 32'h000);
        mid_instr <= 1'b0;
        expect_none(4 * MC);
        wr(`REG_FLAGS, 32'h002);
        expect_call(16'h004B, 4'h3);
        wr(`REG_EN_A, 32'h00);
        leave_isr();
        // External 0 in level mode follows its pin
        wr(`REG_EXT_CTL, 32'h00);
        wr(`REG_EN_A, 32'h81);
        wr(`REG_FLAGS, 32'h100);
        rd_chk(`REG_FLAGS, 32'h000, 32'h100);
        pin_v.ext0_req_pin_n <= 1'b0;
        expect_call(16'h0003, 4'h0);
        rd_chk(`REG_FLAGS, 32'h100, 32'h100);
        pin_v.ext0_req_pin_n <= 1'b1;
        repeat (3 * MC) @(posedge clk_sys);
        rd_chk(`REG_FLAGS, 32'h000, 32'h100);
        wr(`REG_EN_A, 32'h00);
        leave_isr();
        // Pin edges: rising on external 4, reload only when enabled
        wr(`REG_EN_B, 32'h08);
        wr(`REG_EN_A, 32'h80);
        pin_v.ext4_pin <= 1'b1;
        expect_call(16'h005B, 4'h7);
        rd_chk(`REG_FLAGS, 32'h0, 32'h8);
        wr(`REG_EN_A, 32'h00);
        leave_isr();
        wr(`REG_EN_B, 32'h00);
        reload_pulse();
        rd_chk(`REG_FLAGS, 32'h000, 32'h80);
        wr(`REG_EN_B, 32'h80);
        reload_pulse();
        rd_chk(`REG_FLAGS, 32'h080, 32'h80);
        // Reset in mid-run: enables and the reload flag return to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(`REG_EN_B, 32'h0, 32'hFF);
        rd_chk(`REG_FLAGS, 32'h0, 32'h80);
        finish_test();
    end
endmodule : tb

// file: rtl/prioritized_vector_interrupt_ctl.sv
// Prioritised vectored interrupt controller with AHB-Lite registers
// What this block does
// - Each group's level from two priority bits
// - Preempt only by strictly higher level
// - Highest pending level is serviced first
// - Equal level: first source, lower group
// - Six fixed source pairs in polling order
// - High:low bits encode level zero to three
// - Sample flags each machine cycle, poll next
// - Block call: equal or higher level in service, mid-instruction, return/enable or priority write
// - One more instruction after return or enable/priority write
// - No pending memory; cleared requests are dropped
// - Late higher request vectored after one instruction of the lower routine
// - Two-cycle hardware call loads source vector
// - Fixed vectors eight bytes apart, wake highest
// - Interrupt return clears current level's service
// - External 0/1 cleared only when edge mode
// - External 0/1: low level or falling edge
// - External 4-6 rising; reload falls when enabled
// - Edge flags except reload cleared when routine is called
// - At least three cycles flag to routine
// - Blocking adds at most three or five cycles
// - Software writes flags like hardware, except level
`timescale 1ns/100ps
`include "irq_ctl_defs.svh"
module prioritized_vector_interrupt_ctl #(
    parameter int VEC_W = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire irq_ctl_pkg::core_in_s core_in,
    input  wire irq_ctl_pkg::periph_s  periph,
    input  wire irq_ctl_pkg::pins_s    pins,
    output irq_ctl_pkg::core_out_s     core_out
);
    import irq_ctl_pkg::*;

    if (VEC_W != 16) begin : g_bad_w
        $error("Vector width must be 16");
    end

    // ======================================================================
    // Bus slave
    logic [7:0]            en_a_r, en_b_r, pl_r, ph_r, ectl_r;
    logic [`NFLAG-1:0]     fl_r, fl_nxt;
    logic [3:0]            isv_r, isv_nxt;
    logic [31:0]           hrdata_r, rd_data;
    logic                  ap_wr_r;
    logic [`ADDR_W-1:0]    ap_addr_r;
    wire                   ap_take = hsel & htrans[1] & hready;
    wire [`ADDR_W-1:0]     a_ad = haddr[`ADDR_W-1:0];
    wire                   wr_en_a = ap_wr_r & (ap_addr_r == `REG_EN_A);
    wire                   wr_en_b = ap_wr_r & (ap_addr_r == `REG_EN_B);
    wire                   wr_pl = ap_wr_r & (ap_addr_r == `REG_PRIO_LO);
    wire                   wr_ph = ap_wr_r & (ap_addr_r == `REG_PRIO_HI);
    wire                   wr_fl = ap_wr_r & (ap_addr_r == `REG_FLAGS);
    wire                   wr_ec = ap_wr_r & (ap_addr_r == `REG_EXT_CTL);

    always_comb begin
        case (a_ad)
            `REG_EN_A:    rd_data = {24'h000000, en_a_r};
            `REG_EN_B:    rd_data = {24'h000000, en_b_r};
            `REG_PRIO_LO: rd_data = {26'h0000000, pl_r[5:0]};
            `REG_PRIO_HI: rd_data = {26'h0000000, ph_r[5:0]};
            `REG_FLAGS:   rd_data = {21'h000000, fl_r};
            `REG_EXT_CTL: rd_data = {29'h00000000, ectl_r[2:0]};
            `REG_STATUS:  rd_data = {4'h0, core_out.vector, 8'h00, isv_r};
            default:      rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ap_wr_r   <= 1'b0;
            ap_addr_r <= `RST_BYTE;
            hrdata_r  <= 32'h00000000;
        end else begin
            ap_wr_r   <= ap_take & hwrite;
            ap_addr_r <= a_ad;
            if (ap_take & ~hwrite) begin
                hrdata_r <= rd_data;
            end
        end
    end

    // Zero wait states; every access answers OKAY
    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            en_a_r <= `RST_BYTE;
            en_b_r <= `RST_BYTE;
            pl_r   <= `RST_BYTE;
            ph_r   <= `RST_BYTE;
            ectl_r <= `RST_BYTE;
        end else begin
            if (wr_en_a) en_a_r <= hwdata[7:0];
            if (wr_en_b) en_b_r <= hwdata[7:0];
            if (wr_pl)   pl_r   <= hwdata[7:0];
            if (wr_ph)   ph_r   <= hwdata[7:0];
            if (wr_ec)   ectl_r <= hwdata[7:0];
        end
    end

    // ======================================================================
    // Pin synchronisers and machine-cycle samples
    logic [`NPIN-1:0] s1_r, s2_r, s3_r, pq_r, smp_r;
    wire              tick = core_in.mc_tick;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= 7'h03;
            s2_r  <= 7'h03;
            s3_r  <= 7'h03;
            pq_r  <= 7'h03;
            smp_r <= 7'h03;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Accept a change only once two stages agree
            if (s2_r == s3_r) pq_r <= s3_r;
            if (tick) smp_r <= pq_r;
        end
    end

    // Transitions between successive machine-cycle samples
    wire [`NPIN-1:0] rise = {`NPIN{tick}} & pq_r & ~smp_r;
    wire [`NPIN-1:0] fall = {`NPIN{tick}} & ~pq_r & smp_r;
    wire             edge0 = ectl_r[`EXT_TYPE0];
    wire             edge1 = ectl_r[`EXT_TYPE1];
    wire             ex3_hit = ectl_r[`EXT_E3_RISE] ? rise[`PIN_EX3] : fall[`PIN_EX3];

    // ======================================================================
    // Request flags
    logic [`NFLAG-1:0] hw_set, hw_clr;
    logic [12:0]       ack_nxt;

    always_comb begin
        hw_set = '0;
        hw_set[`FL_CONV]  = periph.conv_done_set;
        hw_set[`FL_EX3]   = ex3_hit | periph.cmp_evt[0];
        hw_set[`FL_EX4]   = rise[`PIN_EX4] | periph.cmp_evt[1];
        hw_set[`FL_EX5]   = rise[`PIN_EX5] | periph.cmp_evt[2];
        hw_set[`FL_EX6]   = rise[`PIN_EX6] | periph.cmp_evt[3];
        hw_set[`FL_T2OVF] = periph.t2_ovf_set;
        hw_set[`FL_T2REL] = fall[`PIN_T2REL] & en_b_r[`EN_B_T2REL];
        hw_set[`FL_EXT0]  = edge0 & fall[`PIN_EXT0];
        hw_set[`FL_EXT1]  = edge1 & fall[`PIN_EXT1];
        hw_set[`FL_WAKE]  = periph.wake_set;
        hw_clr = '0;
        hw_clr[`FL_SOFT]  = ack_nxt[3];
        hw_clr[`FL_EX3]   = ack_nxt[5];
        hw_clr[`FL_EX4]   = ack_nxt[7];
        hw_clr[`FL_EX5]   = ack_nxt[9];
        hw_clr[`FL_EX6]   = ack_nxt[11];
        hw_clr[`FL_EXT0]  = ack_nxt[0] & edge0;
        hw_clr[`FL_EXT1]  = ack_nxt[4] & edge1;
        hw_clr[`FL_WAKE]  = ack_nxt[`SRC_WAKE];
        // Set wins over any clear; software acts as hardware would
        fl_nxt = hw_set | (wr_fl ? hwdata[`NFLAG-1:0] : (fl_r & ~hw_clr));
        // Level mode: the flag follows the sampled pin, writes ignored
        if (!edge0) fl_nxt[`FL_EXT0] = tick ? ~pq_r[`PIN_EXT0] : fl_r[`FL_EXT0];
        if (!edge1) fl_nxt[`FL_EXT1] = tick ? ~pq_r[`PIN_EXT1] : fl_r[`FL_EXT1];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) fl_r <= '0;
        else        fl_r <= fl_nxt;
    end

    // ======================================================================
    // Requests in polling order and their sampling
    logic [`NSRC-1:0] req, req_smp_r;
    wire              all_en = en_a_r[`EN_A_ALL];

    assign req = {`NSRC{all_en}} & {
        fl_nxt[`FL_WAKE],
        fl_nxt[`FL_EX6]  & en_b_r[5],
        (fl_nxt[`FL_T2OVF] | fl_nxt[`FL_T2REL]) & en_a_r[5],
        fl_nxt[`FL_EX5]  & en_b_r[4],
        periph.serial    & en_a_r[4],
        fl_nxt[`FL_EX4]  & en_b_r[3],
        periph.t1_ovf    & en_a_r[3],
        fl_nxt[`FL_EX3]  & en_b_r[2],
        fl_nxt[`FL_EXT1] & en_a_r[2],
        fl_nxt[`FL_SOFT] & en_b_r[1],
        periph.t0_ovf    & en_a_r[1],
        fl_nxt[`FL_CONV] & en_b_r[0],
        fl_nxt[`FL_EXT0] & en_a_r[0]
    };

    // Fresh every machine cycle: a request not seen at the tick is forgotten
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)    req_smp_r <= '0;
        else if (tick) req_smp_r <= req;
    end

    // ======================================================================
    // Arbitration
    function automatic lvl_t src_lvl(input int s, input logic [7:0] lo, input logic [7:0] hi);
        if (s == `SRC_WAKE) return `LVL_TOP;
        return {hi[s/2], lo[s/2]};
    endfunction

    function automatic logic [15:0] src_vec(input int s);
        if (s == `SRC_WAKE) return `VEC_WAKE;
        if (s[0]) return `VEC_BASE + `VEC_SOFT_GAP + 16'(s / 2) * `VEC_STEP;
        return `VEC_BASE + 16'(s / 2) * `VEC_STEP;
    endfunction

    logic       win_ok;
    logic [3:0] win_idx;
    lvl_t       win_lvl, cur_lvl;

    always_comb begin
        win_ok  = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        // Ascending scan with strict compare keeps the first at the top level
        for (int s = 0; s < `NSRC; s++) begin
            if (req_smp_r[s] && (!win_ok || src_lvl(s, pl_r, ph_r) > win_lvl)) begin
                win_ok  = 1'b1;
                win_idx = 4'(s);
                win_lvl = src_lvl(s, pl_r, ph_r);
            end
        end
        cur_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (isv_r[l]) cur_lvl = 2'(l);
        end
    end

    // ======================================================================
    // Blocking and the hardware call
    call_st_e st_r, st_nxt;
    logic     blk_r;
    wire      blk_evt = core_in.return_from_irq | wr_en_a | wr_en_b | wr_pl | wr_ph;
    wire      higher = (isv_r == 4'h0) | (win_lvl > cur_lvl);
    wire      grant = tick & core_in.last_cycle & ~blk_r & ~blk_evt
                      & (st_r == CALL_IDLE) & win_ok & higher;

    // The blocking instruction itself ends, then one more must run
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)                            blk_r <= 1'b0;
        else if (blk_evt)                      blk_r <= 1'b1;
        else if (tick & core_in.last_cycle)    blk_r <= 1'b0;
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CALL_IDLE: if (grant) st_nxt = CALL_ONE;
            CALL_ONE:  if (tick)  st_nxt = CALL_TWO;
            CALL_TWO:  if (tick)  st_nxt = CALL_IDLE;
            default:              st_nxt = CALL_IDLE;
        endcase
    end

    always_comb begin
        ack_nxt = '0;
        if (grant) ack_nxt[win_idx] = 1'b1;
        isv_nxt = isv_r;
        // Clear the current level on interrupt return only
        if (core_in.return_from_irq) isv_nxt[cur_lvl] = 1'b0;
        if (grant) isv_nxt[win_lvl] = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= CALL_IDLE;
            isv_r    <= 4'h0;
            core_out <= '0;
        end else begin
            st_r            <= st_nxt;
            isv_r           <= isv_nxt;
            core_out.call   <= (st_nxt != CALL_IDLE);
            core_out.ack    <= ack_nxt;
            if (grant) core_out.vector <= src_vec(int'(win_idx));
        end
    end

    // ======================================================================
    // Checks
    logic [1:0] call_mc_r;
    lvl_t       top_req_lvl;
    logic [3:0] top_req_idx;

    // Machine cycles seen while the call stands; cleared at each grant
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)                    call_mc_r <= 2'h0;
        else if (grant)                call_mc_r <= 2'h0;
        else if (core_out.call & tick) call_mc_r <= call_mc_r + 2'h1;
    end

    // Two passes, unlike the arbiter: top level first, then lowest index at it
    always_comb begin
        top_req_lvl = 2'h0;
        top_req_idx = 4'h0;
        for (int s = 0; s < `NSRC; s++) begin
            if (req_smp_r[s] && src_lvl(s, pl_r, ph_r) > top_req_lvl) begin
                top_req_lvl = src_lvl(s, pl_r, ph_r);
            end
        end
        for (int s = `NSRC - 1; s >= 0; s--) begin
            if (req_smp_r[s] && src_lvl(s, pl_r, ph_r) == top_req_lvl) begin
                top_req_idx = 4'(s);
            end
        end
    end

    sequence s_call_end;
        $fell(core_out.call);
    endsequence

    chk_grant_final: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant |-> core_in.last_cycle && !blk_r && !core_in.return_from_irq)
        else $error("call issued while blocked");

    chk_strict_higher: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant && isv_r != 4'h0 |-> win_lvl > cur_lvl)
        else $error("preempted by equal or lower level");

    chk_top_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant |-> win_lvl == top_req_lvl)
        else $error("lower level chosen");

    chk_poll_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant |-> win_idx == top_req_idx)
        else $error("polling order not kept");

    chk_sampled_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant |-> req_smp_r[win_idx])
        else $error("call without sampled request");

    chk_isv_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        grant |=> isv_r[$past(win_lvl)] && core_out.call && core_out.ack[$past(win_idx)])
        else $error("service bit or call not set");

    chk_vec_align: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_out.call |-> core_out.vector[2:0] == 3'h3)
        else $error("vector not on eight-byte slot");

    chk_call_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_call_end |-> call_mc_r == `CALL_MC)
        else $error("call shorter than two machine cycles");

    chk_return_from_irq_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_in.return_from_irq && isv_r != 4'h0 |=> !isv_r[$past(cur_lvl)])
        else $error("service bit kept after return");

    chk_block_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
        blk_evt |=> blk_r)
        else $error("no extra instruction after blocking event");

    chk_level_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick && !edge0 && !wr_ec |=> fl_r[`FL_EXT0] == !$past(pq_r[`PIN_EXT0]))
        else $error("level flag does not follow pin");

    chk_edge_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ack_nxt[7] && !hw_set[`FL_EX4] && !wr_fl |=> !fl_r[`FL_EX4])
        else $error("edge flag kept after call");

endmodule : prioritized_vector_interrupt_ctl

// file: shared/irq_ctl_defs.svh
// Register map, field positions, vectors and source indexes of the interrupt controller
`ifndef IRQ_CTL_DEFS_SVH
`define IRQ_CTL_DEFS_SVH
// ==========================================================================
// Register byte offsets
`define REG_EN_A      8'h00
`define REG_EN_B      8'h04
`define REG_PRIO_LO   8'h08
`define REG_PRIO_HI   8'h0C
`define REG_FLAGS     8'h10
`define REG_EXT_CTL   8'h14
`define REG_STATUS    8'h18
`define ADDR_W        8
// ==========================================================================
// Field positions
`define EN_A_ALL      7
`define EN_B_T2REL    7
`define EXT_TYPE0     0
`define EXT_TYPE1     1
`define EXT_E3_RISE   2
`define RST_BYTE      8'h00
// ==========================================================================
// Flag bits in the flag register
`define FL_CONV       0
`define FL_SOFT       1
`define FL_EX3        2
`define FL_EX4        3
`define FL_EX5        4
`define FL_EX6        5
`define FL_T2OVF      6
`define FL_T2REL      7
`define FL_EXT0       8
`define FL_EXT1       9
`define FL_WAKE       10
`define NFLAG         11
// ==========================================================================
// Pin bits after synchronising
`define PIN_EXT0      0
`define PIN_EXT1      1
`define PIN_EX3       2
`define PIN_EX4       3
`define PIN_EX5       4
`define PIN_EX6       5
`define PIN_T2REL     6
`define NPIN          7
// ==========================================================================
// Sources in polling order, vector layout
`define NSRC          13
`define NGRP          6
`define SRC_WAKE      12
`define VEC_BASE      16'h0003
`define VEC_STEP      16'h0008
`define VEC_SOFT_GAP  16'h0040
`define VEC_WAKE      16'h007B
`define LVL_TOP       2'h3
`define CALL_MC       2'h2
`endif

// file: shared/irq_ctl_pkg.sv
// Types shared by the interrupt controller and its surroundings
package irq_ctl_pkg;
    typedef logic [1:0] lvl_t;
    typedef enum logic [2:0] {
        CALL_IDLE = 3'b001,
        CALL_ONE  = 3'b010,
        CALL_TWO  = 3'b100
    } call_st_e;
    typedef struct packed {
        logic mc_tick;
        logic last_cycle;
        logic return_from_irq;
    } core_in_s;
    typedef struct packed {
        logic       call;
        logic [15:0] vector;
        logic [12:0] ack;
    } core_out_s;
    typedef struct packed {
        logic       t0_ovf;
        logic       t1_ovf;
        logic       serial;
        logic       t2_ovf_set;
        logic       conv_done_set;
        logic [3:0] cmp_evt;
        logic       wake_set;
    } periph_s;
    typedef struct packed {
        logic t2_reload_pin;
        logic ext6_pin;
        logic ext5_pin;
        logic ext4_pin;
        logic ext3_pin;
        logic ext1_req_pin_n;
        logic ext0_req_pin_n;
    } pins_s;
endpackage : irq_ctl_pkg
